// [icp_config_port.sv]
// Two-wire slave configuration port with the converter register file
`timescale 1ns/1ns
`default_nettype none
module icp_config_port #(
	parameter logic       ENABLE_AT_START = 1'b0,  // Device option for the enable bit
	parameter logic [7:0] CHIP_IDENTITY   = 8'h5A  // Arbitrary neutral identity value
) (
	// Core clock and reset
	input  wire logic       core_clk,
	input  wire logic       resetn,
	// Link sampling clock
	input  wire logic       linkClk,
	// Two-wire bus pins
	input  wire logic       scl,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	// Converter side inputs, asynchronous levels
	input  wire logic       setpointSelectPin,
	input  wire logic       overtemperatureCond,
	input  wire logic       regulationLostCond,
	// Converter controls
	output logic            converterEnable,
	output logic            outputRangeHigh,
	output logic            forcedPulseWidthOn,
	output logic            rampPulseWidthOn,
	output logic      [1:0] slewRateSel,
	output logic      [6:0] activeSetpoint,
	output logic            voltageScalingRamp
);

	localparam logic [7:0] CONTROL_RESET = ENABLE_AT_START ? icp_pkg::CONTROL_RESET_ON
	                                                       : icp_pkg::CONTROL_RESET_OFF;

	// Link domain state
	typedef struct packed {
		icp_pkg::icp_link_state_t state;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic       rw;
		logic       mack;
		logic [7:0] regAddr;
		logic       sclPrev;
		logic       sdaPrev;
		logic       sdaOe;
		logic       sdaOut;
		logic       reqWrite;
		logic [7:0] reqAddr;
		logic [7:0] reqData;
		logic       reqPulse;
		logic       busy;
		logic [7:0] rdData;
		logic       rdValid;
	} icp_link_t;

	// Core domain state
	typedef struct packed {
		logic [7:0] control;
		logic [6:0] setpointA;
		logic [6:0] setpointB;
		logic       overtempFlag;
		logic       regLostFlag;
		logic       primed;
		logic       selPrev;
		logic [6:0] active;
		logic       rampStart;
		logic [7:0] ansData;
		logic       ansPulse;
	} icp_core_t;

	icp_link_t l_r;
	icp_link_t l_nxt;
	icp_core_t c_r;
	icp_core_t c_nxt;

	logic [1:0] linkPins;
	logic [2:0] corePins;
	logic       reqEvt;
	logic       ansEvt;
	logic       sclS;
	logic       sdaS;
	logic       selS;
	logic       otS;
	logic       rlS;

	// Read value of one register; unmapped addresses give zero
	function automatic logic [7:0] regValue(input logic [7:0] addr, input icp_core_t c,
	                                        input logic ot, input logic rl);
		logic [7:0] v;
		v = icp_pkg::UNMAPPED_READ;
		case (addr)
			icp_pkg::OFS_CONTROL:    v = c.control;
			icp_pkg::OFS_STATUS: begin
				v = 8'h00;
				v[icp_pkg::STS_OVERTEMP_BIT] = c.overtempFlag | ot;
				v[icp_pkg::STS_REGLOST_BIT]  = c.regLostFlag | rl;
			end
			icp_pkg::OFS_IDENTITY:   v = CHIP_IDENTITY;
			icp_pkg::OFS_SETPOINT_A: v = {1'b0, c.setpointA};
			icp_pkg::OFS_SETPOINT_B: v = {1'b0, c.setpointB};
			default:                 v = icp_pkg::UNMAPPED_READ;
		endcase
		return v;
	endfunction

	// Pins settle through two flops before the link engine looks at them
	icp_bit_sync #(
		.WIDTH (2)
	) u_link_sync (
		.clk     (linkClk),
		.resetn  (resetn),
		.asyncIn ({scl, sdaIn}),
		.syncOut (linkPins)
	);

	// Converter side levels into the core domain
	icp_bit_sync #(
		.WIDTH (3)
	) u_core_sync (
		.clk     (core_clk),
		.resetn  (resetn),
		.asyncIn ({setpointSelectPin, overtemperatureCond, regulationLostCond}),
		.syncOut (corePins)
	);

	// Register access requests from link to core
	icp_event_cross u_req_cross (
		.srcClk   (linkClk),
		.srcPulse (l_r.reqPulse),
		.dstClk   (core_clk),
		.dstPulse (reqEvt),
		.resetn   (resetn)
	);

	// Completion with read data from core to link
	icp_event_cross u_ans_cross (
		.srcClk   (core_clk),
		.srcPulse (c_r.ansPulse),
		.dstClk   (linkClk),
		.dstPulse (ansEvt),
		.resetn   (resetn)
	);

	assign sclS = linkPins[1];
	assign sdaS = linkPins[0];
	assign selS = corePins[2];
	assign otS  = corePins[1];
	assign rlS  = corePins[0];

	// Link engine: oversamples the bus, frames bytes and drives acknowledges
	always_comb begin
		logic sclRise;
		logic sclFall;
		logic startSeen;
		logic stopSeen;
		sclRise   = sclS & ~l_r.sclPrev;
		sclFall   = ~sclS & l_r.sclPrev;
		startSeen = l_r.sclPrev & sclS & l_r.sdaPrev & ~sdaS;
		stopSeen  = l_r.sclPrev & sclS & ~l_r.sdaPrev & sdaS;
		l_nxt          = l_r;
		l_nxt.sclPrev  = sclS;
		l_nxt.sdaPrev  = sdaS;
		l_nxt.reqPulse = 1'b0;
		l_nxt.sdaOut   = 1'b0;
		// Core answer arrives; read data held until a byte is loaded
		if (ansEvt) begin
			l_nxt.rdData  = c_r.ansData;
			l_nxt.rdValid = 1'b1;
			l_nxt.busy    = 1'b0;
		end
		if (startSeen) begin
			l_nxt.state  = icp_pkg::LK_ADDR;
			l_nxt.bitCnt = 4'h0;
			l_nxt.sdaOe  = 1'b0;
		end else if (stopSeen) begin
			l_nxt.state  = icp_pkg::LK_IDLE;
			l_nxt.sdaOe  = 1'b0;
		end else begin
			case (l_r.state)
				icp_pkg::LK_ADDR, icp_pkg::LK_REG, icp_pkg::LK_WDATA: begin
					// Bits are taken on the rising clock, stable while high
					if (sclRise) begin
						l_nxt.shift  = {l_r.shift[6:0], sdaS};
						l_nxt.bitCnt = l_r.bitCnt + 4'h1;
					end
					if (sclFall && l_r.bitCnt == icp_pkg::BITS_PER_BYTE) begin
						l_nxt.bitCnt = 4'h0;
						if (l_r.state == icp_pkg::LK_ADDR) begin
							if (l_r.shift[7:1] == icp_pkg::SLAVE_ADDR) begin
								l_nxt.rw    = l_r.shift[0];
								l_nxt.sdaOe = 1'b1;
								l_nxt.state = icp_pkg::LK_ADDR_ACK;
							end else begin
								l_nxt.state = icp_pkg::LK_IDLE;
							end
						end else if (l_r.state == icp_pkg::LK_REG) begin
							l_nxt.regAddr = l_r.shift;
							l_nxt.sdaOe   = 1'b1;
							l_nxt.state   = icp_pkg::LK_REG_ACK;
						end else begin
							l_nxt.reqData = l_r.shift;
							l_nxt.sdaOe   = 1'b1;
							l_nxt.state   = icp_pkg::LK_WDATA_ACK;
						end
					end
				end
				icp_pkg::LK_ADDR_ACK: begin
					// A read fetches its byte while the acknowledge is high
					if (sclRise && l_r.rw && !l_r.busy) begin
						l_nxt.reqWrite = 1'b0;
						l_nxt.reqAddr  = l_r.regAddr;
						l_nxt.reqPulse = 1'b1;
						l_nxt.busy     = 1'b1;
						l_nxt.rdValid  = 1'b0;
					end
					if (sclFall) begin
						l_nxt.sdaOe = 1'b0;
						l_nxt.state = l_r.rw ? icp_pkg::LK_RD_WAIT : icp_pkg::LK_REG;
					end
				end
				icp_pkg::LK_REG_ACK: begin
					if (sclFall) begin
						l_nxt.sdaOe = 1'b0;
						l_nxt.state = icp_pkg::LK_WDATA;
					end
				end
				icp_pkg::LK_WDATA_ACK: begin
					// Write is launched at the falling edge of its acknowledge
					if (sclFall) begin
						l_nxt.sdaOe = 1'b0;
						l_nxt.state = icp_pkg::LK_WDATA;
						if (!l_r.busy) begin
							l_nxt.reqWrite = 1'b1;
							l_nxt.reqAddr  = l_r.regAddr;
							l_nxt.reqPulse = 1'b1;
							l_nxt.busy     = 1'b1;
						end
						l_nxt.regAddr = l_r.regAddr + 8'h01;
					end
				end
				icp_pkg::LK_RD_WAIT: begin
					// First data bit goes out once data is here and the clock is low
					if (l_r.rdValid && !sclS) begin
						l_nxt.shift   = l_r.rdData;
						l_nxt.sdaOe   = ~l_r.rdData[7];
						l_nxt.bitCnt  = 4'h0;
						l_nxt.rdValid = 1'b0;
						l_nxt.state   = icp_pkg::LK_RD_SEND;
					end
				end
				icp_pkg::LK_RD_SEND: begin
					if (sclFall) begin
						if (l_r.bitCnt == icp_pkg::LAST_SEND_BIT) begin
							l_nxt.sdaOe = 1'b0;
							l_nxt.state = icp_pkg::LK_RD_ACK;
						end else begin
							l_nxt.shift  = {l_r.shift[6:0], 1'b0};
							l_nxt.sdaOe  = ~l_r.shift[6];
							l_nxt.bitCnt = l_r.bitCnt + 4'h1;
						end
					end
				end
				icp_pkg::LK_RD_ACK: begin
					// Master acknowledge asks for the next register
					if (sclRise) begin
						l_nxt.mack = ~sdaS;
						if (!sdaS && !l_r.busy) begin
							l_nxt.reqWrite = 1'b0;
							l_nxt.reqAddr  = l_r.regAddr + 8'h01;
							l_nxt.reqPulse = 1'b1;
							l_nxt.busy     = 1'b1;
							l_nxt.rdValid  = 1'b0;
							l_nxt.regAddr  = l_r.regAddr + 8'h01;
						end
					end
					if (sclFall) begin
						l_nxt.state = l_r.mack ? icp_pkg::LK_RD_WAIT : icp_pkg::LK_IDLE;
					end
				end
				default: begin
					l_nxt.state = icp_pkg::LK_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge linkClk or negedge resetn) begin
		if (!resetn) begin
			l_r       <= '0;
			l_r.state <= icp_pkg::LK_IDLE;
		end else begin
			l_r <= l_nxt;
		end
	end

	// Core register file, fault flags and ramp trigger
	always_comb begin
		logic [6:0] newActive;
		newActive       = selS ? c_r.setpointB : c_r.setpointA;
		c_nxt           = c_r;
		c_nxt.ansPulse  = 1'b0;
		c_nxt.rampStart = 1'b0;
		c_nxt.primed    = 1'b1;
		c_nxt.selPrev   = selS;
		// Select pin change starts a ramp, also a pin already high at reset once it passes the synchroniser
		if (c_r.primed && (selS != c_r.selPrev)) begin
			c_nxt.rampStart = 1'b1;
		end
		if (reqEvt) begin
			if (l_r.reqWrite) begin
				case (l_r.reqAddr)
					icp_pkg::OFS_CONTROL: begin
						c_nxt.control = l_r.reqData;
					end
					icp_pkg::OFS_SETPOINT_A: begin
						c_nxt.setpointA = l_r.reqData[6:0];
						if (!selS && (l_r.reqData[6:0] != c_r.setpointA)) begin
							c_nxt.rampStart = 1'b1;
						end
					end
					icp_pkg::OFS_SETPOINT_B: begin
						c_nxt.setpointB = l_r.reqData[6:0];
						if (selS && (l_r.reqData[6:0] != c_r.setpointB)) begin
							c_nxt.rampStart = 1'b1;
						end
					end
					default: begin
						c_nxt.control = c_r.control;                // Read-only or unmapped
					end
				endcase
			end else begin
				c_nxt.ansData = regValue(l_r.reqAddr, c_r, otS, rlS);
				if (l_r.reqAddr == icp_pkg::OFS_STATUS) begin
					c_nxt.overtempFlag = 1'b0;
					c_nxt.regLostFlag  = 1'b0;
				end
			end
			c_nxt.ansPulse = 1'b1;
		end
		// A present fault keeps or sets its flag, winning over a clearing read
		if (otS) begin
			c_nxt.overtempFlag = 1'b1;
		end
		if (rlS) begin
			c_nxt.regLostFlag = 1'b1;
		end
		c_nxt.active = selS ? c_nxt.setpointB : c_nxt.setpointA;
		if (newActive != c_nxt.active) begin
			c_nxt.active = c_nxt.active;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			c_r           <= '0;
			c_r.control   <= CONTROL_RESET;
			c_r.setpointA <= icp_pkg::SETPOINT_A_RESET;
			c_r.setpointB <= icp_pkg::SETPOINT_B_RESET;
			c_r.active    <= icp_pkg::SETPOINT_A_RESET;
		end else begin
			c_r <= c_nxt;
		end
	end

	// Outputs straight from state flops
	assign sdaOut             = l_r.sdaOut;
	assign sdaOe              = l_r.sdaOe;
	assign converterEnable    = c_r.control[icp_pkg::CTL_ENABLE_BIT];
	assign outputRangeHigh    = c_r.control[icp_pkg::CTL_RANGE_BIT];
	assign forcedPulseWidthOn = c_r.control[icp_pkg::CTL_FORCED_PULSE_WIDTH_ON_BIT];
	assign rampPulseWidthOn   = c_r.control[icp_pkg::CTL_RAMP_PULSE_WIDTH_ON_BIT];
	assign slewRateSel        = c_r.control[icp_pkg::CTL_SLEW_MSB:icp_pkg::CTL_SLEW_LSB];
	assign activeSetpoint     = c_r.active;
	assign voltageScalingRamp = c_r.rampStart;

endmodule
`default_nettype wire

// [icp_pkg.sv]
// Constants, register map and state codes of the converter configuration port
// How it works
// - Slave only, answers 7-bit address 1110101b; no 10-bit or general call.
// - Same protocol at 100 kbps, 400 kbps and 1 Mbps bit rates.
// - SDA falling while SCL high is START, recognised in every state.
// - Address byte is acknowledged only on a match, SDA low in ninth clock.
// - Every byte is followed by one acknowledge bit from the receiver.
// - SDA rising while SCL high is STOP; slave releases and waits.
// - Reads of unmapped register addresses return 00h without side effects.
// - Write is START, address+W, register address, data; each byte acknowledged.
// - Written data lands at the falling edge of the final acknowledge clock.
// - Control bits 7 and 4 are plain storage without function.
// - Control bit 6 selects output range, low 1.800 V or high 2.025 V.
// - Control bit 5 enables converter; reset 0x00 or 0x20 by option.
// - Control bit 3 turns forced PWM on; resets to 0.
// - Control bit 2 turns ramp PWM on; resets to 0.
// - Control bits 1:0 pick slew rate 1.0, 2.5, 5.0 or 10.0 V/ms.
// - Status at 0x02 is read-only, reset 0x00, bit1 thermal, bit0 regulation.
// - Status flag sets on its fault, clears on read once fault is gone.
// - Select pin low picks setpoint A, high picks setpoint B.
// - Ramp starts on select pin change or new value in active setpoint.
package icp_pkg;

	// Bus address of this slave
	localparam logic [6:0] SLAVE_ADDR       = 7'h75;

	// Register offsets
	localparam logic [7:0] OFS_CONTROL      = 8'h01;
	localparam logic [7:0] OFS_STATUS       = 8'h02;
	localparam logic [7:0] OFS_IDENTITY     = 8'h03;
	localparam logic [7:0] OFS_SETPOINT_A   = 8'h04;
	localparam logic [7:0] OFS_SETPOINT_B   = 8'h05;

	// Control register field positions
	localparam int CTL_SPARE_HI_BIT  = 7;
	localparam int CTL_RANGE_BIT     = 6;
	localparam int CTL_ENABLE_BIT    = 5;
	localparam int CTL_SPARE_LO_BIT  = 4;
	localparam int CTL_FORCED_PULSE_WIDTH_ON_BIT      = 3;
	localparam int CTL_RAMP_PULSE_WIDTH_ON_BIT      = 2;
	localparam int CTL_SLEW_MSB      = 1;
	localparam int CTL_SLEW_LSB      = 0;

	// Status register field positions
	localparam int STS_OVERTEMP_BIT  = 1;
	localparam int STS_REGLOST_BIT   = 0;

	// Reset values
	localparam logic [7:0] CONTROL_RESET_OFF = 8'h00;
	localparam logic [7:0] CONTROL_RESET_ON  = 8'h20;
	localparam logic [6:0] SETPOINT_A_RESET  = 7'h3C;
	localparam logic [6:0] SETPOINT_B_RESET  = 7'h42;
	localparam logic [7:0] UNMAPPED_READ     = 8'h00;

	// Slew rate codes
	localparam logic [1:0] SLEW_1V0_PER_MS   = 2'h0;
	localparam logic [1:0] SLEW_2V5_PER_MS   = 2'h1;
	localparam logic [1:0] SLEW_5V0_PER_MS   = 2'h2;
	localparam logic [1:0] SLEW_10V0_PER_MS  = 2'h3;

	// Bits per byte on the wire, counted before the acknowledge slot
	localparam logic [3:0] BITS_PER_BYTE     = 4'h8;
	localparam logic [3:0] LAST_SEND_BIT     = 4'h7;

	// Link engine states
	typedef enum logic [3:0] {
		LK_IDLE      = 4'h0,
		LK_ADDR      = 4'h1,
		LK_ADDR_ACK  = 4'h2,
		LK_REG       = 4'h3,
		LK_REG_ACK   = 4'h4,
		LK_WDATA     = 4'h5,
		LK_WDATA_ACK = 4'h6,
		LK_RD_WAIT   = 4'h7,
		LK_RD_SEND   = 4'h8,
		LK_RD_ACK    = 4'h9
	} icp_link_state_t;

endpackage

// [icp_bit_sync.sv]
// Two flip-flop level synchroniser for a group of independent bits
`timescale 1ns/1ns
`default_nettype none
module icp_bit_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} icp_sync_t;

	icp_sync_t s_r;
	icp_sync_t s_nxt;

	// First stage feeds only the second stage
	always_comb begin
		s_nxt        = s_r;
		s_nxt.stage1 = asyncIn;
		s_nxt.stage2 = s_r.stage1;
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign syncOut = s_r.stage2;

endmodule
`default_nettype wire

// [icp_event_cross.sv]
// Toggle based crossing of a one-cycle event between two clock domains
`timescale 1ns/1ns
`default_nettype none
module icp_event_cross (
	// Source domain
	input  wire logic srcClk,
	input  wire logic srcPulse,
	// Destination domain
	input  wire logic dstClk,
	output logic      dstPulse,
	// Shared asynchronous reset
	input  wire logic resetn
);

	typedef struct packed {
		logic toggle;
	} icp_src_t;

	typedef struct packed {
		logic stage1;
		logic stage2;
		logic stage3;
		logic pulse;
	} icp_dst_t;

	icp_src_t src_r;
	icp_src_t src_nxt;
	icp_dst_t dst_r;
	icp_dst_t dst_nxt;

	// Source flips its toggle once per event
	always_comb begin
		src_nxt        = src_r;
		src_nxt.toggle = src_r.toggle ^ srcPulse;
	end

	always_ff @(posedge srcClk or negedge resetn) begin
		if (!resetn) begin
			src_r <= '0;
		end else begin
			src_r <= src_nxt;
		end
	end

	// Two-stage synchroniser, then an edge detector on the settled copy
	always_comb begin
		dst_nxt        = dst_r;
		dst_nxt.stage1 = src_r.toggle;
		dst_nxt.stage2 = dst_r.stage1;
		dst_nxt.stage3 = dst_r.stage2;
		dst_nxt.pulse  = dst_r.stage2 ^ dst_r.stage3;
	end

	always_ff @(posedge dstClk or negedge resetn) begin
		if (!resetn) begin
			dst_r <= '0;
		end else begin
			dst_r <= dst_nxt;
		end
	end

	assign dstPulse = dst_r.pulse;

endmodule
`default_nettype wire

// [icp_config_port_sva.sv]
// Concurrent checks on the pins of the converter configuration port
`timescale 1ns/1ns
`default_nettype none
module icp_config_port_sva #(
	parameter logic ENABLE_AT_START = 1'b0
) (
	// Clocks and reset
	input wire logic	core_clk,
	input wire logic	linkClk,
	input wire logic	resetn,
	// Bus pins
	input wire logic	scl,
	input wire logic	sdaOut,
	input wire logic	sdaOe,
	// Converter side
	input wire logic	setpointSelectPin,
	input wire logic	converterEnable,
	input wire logic	outputRangeHigh,
	input wire logic	forcedPulseWidthOn,
	input wire logic	rampPulseWidthOn,
	input wire logic [1:0]	slewRateSel,
	input wire logic [6:0]	activeSetpoint,
	input wire logic	voltageScalingRamp
);
	// Ramp strobe close behind a cause
	sequence s_rampSoon;
		##[0:2] voltageScalingRamp;
	endsequence
	// Select pin moved and then held
	sequence s_selMoved;
		$changed(setpointSelectPin) ##1 $stable(setpointSelectPin);
	endsequence
	property p_openDrain;
		@(posedge linkClk) disable iff (!resetn) sdaOut == 1'b0;
	endproperty
	property p_oeSclHigh;
		@(posedge linkClk) disable iff (!resetn) scl && $past(scl) |-> $stable(sdaOe);
	endproperty
	property p_linkReset;
		@(posedge linkClk) !resetn |-> !sdaOe;
	endproperty
	property p_coreReset;
		@(posedge core_clk) !resetn |-> converterEnable == ENABLE_AT_START && !outputRangeHigh
			&& !forcedPulseWidthOn && !rampPulseWidthOn && slewRateSel == 2'h0
			&& activeSetpoint == icp_pkg::SETPOINT_A_RESET && !voltageScalingRamp;
	endproperty
	property p_rampPulse;
		@(posedge core_clk) disable iff (!resetn) voltageScalingRamp |=> !voltageScalingRamp;
	endproperty
	property p_selRamp;
		@(posedge core_clk) disable iff (!resetn) s_selMoved |-> ##[0:6] voltageScalingRamp;
	endproperty
	property p_ctrlAtAckFall;
		@(posedge core_clk) disable iff (!resetn) $changed({outputRangeHigh, converterEnable,
			forcedPulseWidthOn, rampPulseWidthOn, slewRateSel}) |-> !scl;
	endproperty
	property p_setpointRamp;
		@(posedge core_clk) disable iff (!resetn)
			$changed(activeSetpoint) |-> $past(voltageScalingRamp) or s_rampSoon;
	endproperty
	a_openDrain: assert property (p_openDrain)
		else $error("data line driven high");
	a_oeSclHigh: assert property (p_oeSclHigh)
		else $error("data enable moved while clock high");
	a_linkReset: assert property (p_linkReset)
		else $error("data line pulled during reset");
	a_coreReset: assert property (p_coreReset)
		else $error("control outputs off their reset values");
	a_rampPulse: assert property (p_rampPulse)
		else $error("ramp strobe longer than one cycle");
	a_selRamp: assert property (p_selRamp)
		else $error("no ramp after select change");
	a_ctrlAtAckFall: assert property (p_ctrlAtAckFall)
		else $error("control changed while bus clock high");
	a_setpointRamp: assert property (p_setpointRamp)
		else $error("setpoint changed without ramp");
endmodule
bind icp_config_port icp_config_port_sva #(.ENABLE_AT_START(ENABLE_AT_START)) u_sva (
	.core_clk, .linkClk, .resetn, .scl, .sdaOut, .sdaOe, .setpointSelectPin,
	.converterEnable, .outputRangeHigh, .forcedPulseWidthOn, .rampPulseWidthOn,
	.slewRateSel, .activeSetpoint, .voltageScalingRamp
);
`default_nettype wire

// [icp_bus_master.sv]
// Bus master model driving the two-wire port from the far side
`timescale 1ns/1ns
`default_nettype none
module icp_bus_master (
	// Pacing clock
	input wire logic	clk,
	// Wire level of the data line
	input wire logic	sdaWire,
	// Bus clock and data pull-down
	output var logic	scl,
	output var logic	sdaPullLow
);
	// Idle bus: both lines high
	initial begin
		scl = 1'b1;
		sdaPullLow = 1'b0;
	end
	// Quarter bit at 1 Mbps
	task automatic q();
		repeat (25) @(negedge clk);
	endtask
	// Data moves mid low phase, read at the end of the high phase
	task automatic bitx(input logic b, output logic r);
		q();
		sdaPullLow = !b;
		q();
		scl = 1'b1;
		q();
		q();
		r = sdaWire;
		scl = 1'b0;
	endtask
	// Start or repeated start
	task automatic startc();
		q();
		sdaPullLow = 1'b0;
		q();
		scl = 1'b1;
		q();
		sdaPullLow = 1'b1;
		q();
		scl = 1'b0;
	endtask
	// Stop, also issued once after power-up
	task automatic stopc();
		q();
		sdaPullLow = 1'b1;
		q();
		scl = 1'b1;
		q();
		sdaPullLow = 1'b0;
		q();
	endtask
	// Byte out, acknowledge slot released
	task automatic sendb(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'b1, r);
		ack = !r;
	endtask
	// Byte in, then acknowledge or not
	task automatic recvb(input logic ackIt, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(!ackIt, r);
	endtask
endmodule
`default_nettype wire

// [icp_config_port_tb_top.sv]
// Self-checking bench for the converter configuration port
`timescale 1ns/1ns
`default_nettype none
module icp_config_port_tb_top;
	localparam logic [7:0] IDENT = 8'hA7; // Arbitrary identity value
	logic core_clk = 1'b0;
	logic linkClk = 1'b0;
	logic resetn = 1'b1;
	logic sel = 1'b0;
	logic ot = 1'b0;
	logic rl = 1'b0;
	logic scl, pullLow, sdaOe, sdaOut, sdaWire, en, rng, forcedOn, rampOn, ramp, ack;
	logic [1:0] slew;
	logic [6:0] active;
	logic [7:0] rd;
	int num_errors = 0;
	int compares = 0;
	int rampCount = 0;
	// Clocks, link clock offset by 4 ns; its edges still meet core clock edges every 160 ns
	always #5 core_clk = ~core_clk;
	initial begin
		#4;
		linkClk = 1'b1;
		forever #32 linkClk = ~linkClk;
	end
	// Open-drain wire with pull-up
	assign sdaWire = !(pullLow || sdaOe);
	// Ramp strobes counted mid-cycle, away from the edge that launches them
	always @(negedge core_clk) if (ramp === 1'b1) rampCount++;
	icp_config_port #(.ENABLE_AT_START(1'b0), .CHIP_IDENTITY(IDENT)) dut (
		.core_clk(core_clk), .resetn(resetn), .linkClk(linkClk), .scl(scl),
		.sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .setpointSelectPin(sel),
		.overtemperatureCond(ot), .regulationLostCond(rl), .converterEnable(en),
		.outputRangeHigh(rng), .forcedPulseWidthOn(forcedOn), .rampPulseWidthOn(rampOn),
		.slewRateSel(slew), .activeSetpoint(active), .voltageScalingRamp(ramp));
	icp_bus_master bfm (.clk(core_clk), .sdaWire(sdaWire), .scl(scl), .sdaPullLow(pullLow));
	task automatic finish_test();
		$display("Counts: %0d compares, %0d errors", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask
	function automatic logic [7:0] ctl();
		return {1'b0, rng, en, 1'b0, forcedOn, rampOn, slew};
	endfunction
	// Register write with every byte acknowledged
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bfm.startc();
		bfm.sendb(8'hEA, ack);
		chk_bit(ack, 1'b1);
		bfm.sendb(a, ack);
		chk_bit(ack, 1'b1);
		bfm.sendb(d, ack);
		chk_bit(ack, 1'b1);
		bfm.stopc();
	endtask
	// Register read through a repeated start, ended by no-acknowledge
	task automatic rdr(input logic [7:0] a, input logic [7:0] exp);
		bfm.startc();
		bfm.sendb(8'hEA, ack);
		chk_bit(ack, 1'b1);
		bfm.sendb(a, ack);
		bfm.startc();
		bfm.sendb(8'hEB, ack);
		chk_bit(ack, 1'b1);
		bfm.recvb(1'b0, rd);
		bfm.stopc();
		chk_byte(rd, exp);
	endtask
	task automatic t_reset();
		chk_byte(ctl(), 8'h00);
		rdr(8'h01, 8'h00);
		rdr(8'h03, IDENT);
		rdr(8'h04, 8'h3C);
		rdr(8'h05, 8'h42);
		$display("reset values done");
	endtask
	// Every slew code, spare bits stored without effect
	task automatic t_control();
		logic [7:0] v [4] = '{8'h28, 8'h95, 8'h4A, 8'hFF};
		foreach (v[i]) begin
			wr(8'h01, v[i]);
			chk_byte(ctl(), v[i] & 8'h6F);
			rdr(8'h01, v[i]);
		end
		$display("control done");
	endtask
	// Foreign, general call and ten-bit addresses go unanswered
	task automatic t_address();
		logic [7:0] v [3] = '{8'hEC, 8'h00, 8'hF0};
		foreach (v[i]) begin
			bfm.startc();
			bfm.sendb(v[i], ack);
			chk_bit(ack, 1'b0);
			bfm.stopc();
		end
		rdr(8'h00, 8'h00);
		rdr(8'h07, 8'h00);
		$display("address done");
	endtask
	task automatic t_status();
		wr(8'h02, 8'hFF);
		ot = 1'b1;
		repeat (20) @(negedge core_clk);
		ot = 1'b0;
		rdr(8'h02, 8'h02);
		rdr(8'h02, 8'h00);
		rl = 1'b1;
		repeat (20) @(negedge core_clk);
		rdr(8'h02, 8'h01);
		rdr(8'h02, 8'h01);
		rl = 1'b0;
		$display("status done");
	endtask
	task automatic t_setpoint();
		int n;
		n = rampCount;
		wr(8'h04, 8'h10);
		chk_byte({1'b0, active}, 8'h10);
		chk_byte(8'(rampCount - n), 8'h01);
		sel = 1'b1;
		repeat (10) @(negedge core_clk);
		chk_byte({1'b0, active}, 8'h42);
		chk_byte(8'(rampCount - n), 8'h02);
		wr(8'h04, 8'hA0);
		chk_byte({1'b0, active}, 8'h42);
		chk_byte(8'(rampCount - n), 8'h02);
		rdr(8'h04, 8'h20);
		// Two-byte read: master acknowledge fetches the next register
		bfm.startc();
		bfm.sendb(8'hEA, ack);
		bfm.sendb(8'h04, ack);
		bfm.startc();
		bfm.sendb(8'hEB, ack);
		bfm.recvb(1'b1, rd);
		chk_byte(rd, 8'h20);
		bfm.recvb(1'b0, rd);
		chk_byte(rd, 8'h42);
		bfm.stopc();
		$display("setpoint done");
	endtask
	// Main sequence
	initial begin
		#1;
		resetn = 1'b0;
		repeat (2) @(negedge core_clk);
		resetn = 1'b1;
		repeat (40) @(negedge core_clk);
		bfm.stopc();
		t_reset();
		t_control();
		t_address();
		t_status();
		t_setpoint();
		finish_test();
	end
	// Hang guard
	initial begin
		repeat (98000) @(posedge core_clk);
		num_errors++;
		$display("Error at %0t: run too long", $time);
		finish_test();
	end
endmodule
`default_nettype wire
